// ### bench/utrd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module utrd_checker (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        clk_en,
	input wire logic        cpu_wr_data,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_ready_flag,
	input wire logic        tx_enable,
	input wire logic        rx_enable,
	input wire logic        double_speed_bit,
	input wire logic [11:0] rate_divisor,
	input wire logic [2:0]  char_size_field,
	input wire logic        tx_empty_irq_enable,
	input wire logic        tx_done_irq_enable,
	input wire logic        global_irq_enable,
	input wire logic        tx_done_irq_ack,
	input wire logic        tx_done_clear,
	input wire logic        tx_buffer_empty_flag,
	input wire logic        tx_done_flag,
	input wire logic        irq_tx_empty,
	input wire logic        irq_tx_done,
	input wire logic        txd_out,
	input wire logic        txd_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// length of the current low run on the line; at divisor zero without double speed, runs must be whole multiples of 16
	logic [7:0] low_cnt_reg;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			low_cnt_reg <= 8'h00;
		else if (txd_out)
			low_cnt_reg <= 8'h00;
		else
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end
	chk_wr_clears_empty: assert property (clk_en && cpu_wr_data |=> !tx_buffer_empty_flag)
		else $error("buffer empty flag still set after write");
	chk_empty_irq_on: assert property ((clk_en && tx_empty_irq_enable && global_irq_enable
		&& tx_buffer_empty_flag) [*2] |-> irq_tx_empty) else $error("empty request missing");
	chk_empty_irq_off: assert property ((clk_en && !tx_empty_irq_enable) [*2] |-> !irq_tx_empty)
		else $error("empty request while disabled");
	chk_done_irq_on: assert property ((clk_en && tx_done_irq_enable && global_irq_enable
		&& tx_done_flag) [*2] |-> irq_tx_done) else $error("done request missing");
	chk_done_needs_empty: assert property ($rose(tx_done_flag) |-> tx_buffer_empty_flag)
		else $error("done flag set with data buffered");
	chk_done_clear: assert property (clk_en && (tx_done_clear || tx_done_irq_ack) && tx_done_flag
		&& tx_buffer_empty_flag |=> !tx_done_flag) else $error("done flag not cleared");
	chk_oe_take: assert property (clk_en && tx_enable && !txd_oe |=> txd_oe)
		else $error("serial output not taken");
	chk_oe_release: assert property ($fell(txd_oe) |-> !$past(tx_enable)
		&& $past(tx_buffer_empty_flag)) else $error("serial output released early");
	chk_bit_period: assert property ($rose(txd_out) && txd_oe && rate_divisor == 12'h000
		&& !double_speed_bit |-> low_cnt_reg[3:0] == 4'h0) else $error("bit length not 16");
	chk_rx_flush: assert property ((!rx_enable) [*3] |-> !rx_ready_flag && rx_data == 8'h00)
		else $error("receive buffer not flushed");
	chk_short_mask: assert property (rx_ready_flag && char_size_field == 3'h0
		|-> rx_data[7:5] == 3'h0) else $error("upper receive bits not zero");
	cov_tx_done: cover property ($rose(tx_done_flag));
	cov_oe_release: cover property ($fell(txd_oe));
	cov_rx_ready: cover property ($rose(rx_ready_flag));
endmodule // utrd_checker
`default_nettype wire

// ### bench/utrd_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define UTRD_CHK(name, exp, got) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("unexpected %s exp %0h got %0h", name, exp, got); \
	end \
end
module utrd_core_tb;
	logic        mclk, arst_n, clk_en, cpu_wr_data, cpu_rd_data, tx_enable, rx_enable;
	logic        sync_mode, sync_master, sync_clock_polarity, sync_clock_pin_in;
	logic        double_speed_bit, parity_enable_bit, parity_odd, stop_bits_select, tx_ninth_bit;
	logic        tx_empty_irq_enable, tx_done_irq_enable, global_irq_enable;
	logic        tx_done_irq_ack, tx_done_clear;
	logic [7:0]  cpu_wdata;
	logic [11:0] rate_divisor, frame;
	logic [2:0]  char_size_field;
	logic [4:0]  bit_cyc;
	logic [3:0]  cap_bits;
	wire  [7:0]  rx_data;
	wire         rx_ninth_bit, rx_ready_flag, tx_buffer_empty_flag, tx_done_flag, rxd_in;
	wire         irq_tx_empty, irq_tx_done, txd_out, txd_oe, txd_line, xck_out, xck_oe;
	int          fails, total_checks, i;
	// format table: 5E1, 7O1, 6N2 at double speed, 9N1
	logic [2:0]  t_cs  [4] = '{3'h0, 3'h2, 3'h1, 3'h7};
	logic [7:0]  t_wd  [4] = '{8'hE3, 8'h81, 8'h6A, 8'h00};
	logic [11:0] t_fr  [4] = '{12'h043, 12'h101, 12'h0EA, 12'h300};
	logic [3:0]  t_cap [4] = '{4'h7, 4'h9, 4'h8, 4'hA};
	logic [7:0]  t_rx  [4] = '{8'h03, 8'h01, 8'h2A, 8'h00};
	logic [3:0]  t_par = 4'h3, t_odd = 4'h2, t_stop = 4'h4, t_ds = 4'h4, t_nine = 4'h8;
	// line has a pull-up while the block is not driving it
	assign txd_line = txd_oe ? txd_out : 1'b1;
	utrd_core dut_u (.*, .sync_clock_pin_out(xck_out), .sync_clock_pin_oe(xck_oe));
	utrd_remote remote_u (.mclk(mclk), .txd_line(txd_line), .bit_cyc(bit_cyc),
		.cap_bits(cap_bits), .rxd_in(rxd_in));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task summarize;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wait_on(input int sel);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(negedge mclk);
			if ((sel == 0 && tx_buffer_empty_flag === 1'b1) || (sel == 2 && rx_ready_flag === 1'b1)
				|| (sel == 1 && remote_u.frames_q.size() > 0) || (sel == 3 && txd_oe === 1'b0))
				return;
		end
		fails++;
		summarize();
	endtask
	task wr(input logic [7:0] d);
		@(negedge mclk);
		cpu_wr_data = 1'b1;
		cpu_wdata = d;
		@(negedge mclk);
		cpu_wr_data = 1'b0;
	endtask
	task rd(input logic [7:0] e);
		@(negedge mclk);
		`UTRD_CHK("rx_data", e, rx_data)
		cpu_rd_data = 1'b1;
		@(negedge mclk);
		cpu_rd_data = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task pop(input logic [11:0] e);
		wait_on(1);
		frame = remote_u.frames_q.pop_front();
		`UTRD_CHK("tx_frame", e, frame)
	endtask
	initial begin
		{clk_en, cpu_wr_data, cpu_rd_data, tx_enable, rx_enable, sync_mode, sync_master} = 7'h40;
		{sync_clock_polarity, sync_clock_pin_in, double_speed_bit, parity_enable_bit} = 4'h0;
		{parity_odd, stop_bits_select, tx_ninth_bit, tx_empty_irq_enable} = 4'h0;
		{tx_done_irq_enable, global_irq_enable, tx_done_irq_ack, tx_done_clear} = 4'h0;
		{cpu_wdata, rate_divisor, char_size_field} = {8'h00, 12'h000, 3'h3};
		{bit_cyc, cap_bits, fails, total_checks} = {5'h10, 4'h9, 32'h0, 32'h0};
		arst_n = 1'b0;
		repeat (4) @(negedge mclk);
		arst_n = 1'b1;
		`UTRD_CHK("empty_rst", 1'b1, tx_buffer_empty_flag)
		`UTRD_CHK("oe_rst", 1'b0, txd_oe)
		tx_enable = 1'b1;
		rx_enable = 1'b1;
		{tx_empty_irq_enable, tx_done_irq_enable, global_irq_enable} = 3'h7;
		repeat (3) @(negedge mclk);
		`UTRD_CHK("oe_on", 1'b1, txd_oe)
		`UTRD_CHK("irq_empty", 1'b1, irq_tx_empty)
		wr(8'hA5);
		`UTRD_CHK("empty_wr", 1'b0, tx_buffer_empty_flag)
		wait_on(0);
		wr(8'h3C);
		repeat (30) @(negedge mclk);
		`UTRD_CHK("empty_hold", 1'b0, tx_buffer_empty_flag)
		`UTRD_CHK("done_early", 1'b0, tx_done_flag)
		pop(12'h1A5);
		pop(12'h13C);
		repeat (20) @(negedge mclk);
		`UTRD_CHK("done_set", 1'b1, tx_done_flag)
		`UTRD_CHK("irq_done", 1'b1, irq_tx_done)
		tx_done_irq_ack = 1'b1;
		tx_empty_irq_enable = 1'b0;
		@(negedge mclk);
		tx_done_irq_ack = 1'b0;
		@(negedge mclk);
		`UTRD_CHK("done_ack", 1'b0, tx_done_flag)
		`UTRD_CHK("irq_empty_off", 1'b0, irq_tx_empty)
		for (i = 0; i < 4; i++) begin
			char_size_field = t_cs[i];
			{parity_enable_bit, parity_odd, stop_bits_select} = {t_par[i], t_odd[i], t_stop[i]};
			{double_speed_bit, tx_ninth_bit} = {t_ds[i], t_nine[i]};
			bit_cyc = t_ds[i] ? 5'h08 : 5'h10;
			cap_bits = t_cap[i];
			wr(t_wd[i]);
			pop(t_fr[i]);
			remote_u.send(t_fr[i], t_cap[i]);
			wait_on(2);
			if (t_nine[i])
				`UTRD_CHK("rx_ninth", 1'b1, rx_ninth_bit)
			rd(t_rx[i]);
			`UTRD_CHK("done_loop", 1'b1, tx_done_flag)
			tx_done_clear = 1'b1;
			@(negedge mclk);
			tx_done_clear = 1'b0;
			@(negedge mclk);
			`UTRD_CHK("done_clr", 1'b0, tx_done_flag)
		end
		{char_size_field, parity_enable_bit, stop_bits_select, double_speed_bit} = {3'h3, 3'h0};
		{bit_cyc, cap_bits} = {5'h10, 4'h9};
		// sync master: half clock period is divisor+1, so one bit is 16 cycles
		{sync_mode, sync_master, rate_divisor} = {2'h3, 12'h007};
		wr(8'h96);
		`UTRD_CHK("xck_oe", 1'b1, xck_oe)
		pop(12'h196);
		repeat (20) @(negedge mclk);
		{sync_mode, sync_master, rate_divisor} = {2'h0, 12'h000};
		repeat (2) @(negedge mclk);
		`UTRD_CHK("xck_rest", 2'h0, {xck_oe, xck_out})
		for (i = 0; i < 8; i++)
			remote_u.send({4'h1, i[3:0], i[3:0]}, 9);
		@(negedge mclk);
		`UTRD_CHK("rx_full", 1'b1, rx_ready_flag)
		for (i = 0; i < 8; i++)
			rd({i[3:0], i[3:0]});
		`UTRD_CHK("rx_drained", 1'b0, rx_ready_flag)
		wr(8'h55);
		repeat (3) @(negedge mclk);
		tx_enable = 1'b0;
		repeat (40) @(negedge mclk);
		`UTRD_CHK("oe_hold", 1'b1, txd_oe)
		wait_on(3);
		pop(12'h155);
		remote_u.send(12'h1F0, 9);
		@(negedge mclk);
		rx_enable = 1'b0;
		repeat (4) @(negedge mclk);
		`UTRD_CHK("rx_flush", 1'b0, rx_ready_flag)
		// a write while frozen must not touch the buffer
		clk_en = 1'b0;
		wr(8'h0F);
		`UTRD_CHK("empty_frz", 1'b1, tx_buffer_empty_flag)
		clk_en = 1'b1;
		summarize();
	end
endmodule // utrd_core_tb
bind utrd_core utrd_checker chk_u (.*);
`default_nettype wire

// ### bench/utrd_remote.sv
`timescale 1ns/100ps
`default_nettype none
module utrd_remote (
	input  wire logic       mclk,
	input  wire logic       txd_line,
	input  wire logic [4:0] bit_cyc,
	input  wire logic [3:0] cap_bits,
	output var  logic       rxd_in
);
	logic [11:0] frames_q[$];
	logic [11:0] f;
	int          k;
	// listener samples mid-bit, so it re-arms in time for a back-to-back start
	initial begin
		forever begin
			@(negedge txd_line);
			repeat (bit_cyc / 2) @(posedge mclk);
			if (txd_line == 1'b0) begin
				f = 12'h000;
				for (k = 0; k < cap_bits; k++) begin
					repeat (bit_cyc) @(posedge mclk);
					f[k] = txd_line;
				end
				frames_q.push_back(f);
			end
		end
	end
	initial rxd_in = 1'b1;
	task automatic send(input logic [11:0] fr, input int n);
		int j;
		@(posedge mclk);
		rxd_in <= 1'b0;
		repeat (bit_cyc) @(posedge mclk);
		for (j = 0; j < n; j++) begin
			rxd_in <= fr[j];
			repeat (bit_cyc) @(posedge mclk);
		end
		rxd_in <= 1'b1;
	endtask
endmodule // utrd_remote
`default_nettype wire

// ### inc/utrd_regs.vh
//Behaviour
//- tx enable makes the block drive the serial output pin
//- sync mode takes the sync clock pin as transmit clock
//- data write fills buffer; buffer moves to shifter when idle or after stop
//- short characters drop upper written data bits
//- nine-bit characters take ninth bit from tx ninth bit, set before write
//- buffer empty flag is one exactly while transmit buffer is empty
//- empty interrupt requested as a level while flag and enables set
//- data write clears buffer empty flag
//- done flag sets when frame shifted out and buffer is empty
//- done flag clears on interrupt service or on write of one
//- done interrupt raised while done flag set and enables set
//- parity enabled inserts parity after last data bit
//- tx disable waits until shifter and buffer empty, then frees pin
//- rx enable makes the block take the serial input pin
//- sync mode receiver uses sync clock pin as transfer clock
//- receiver starts on valid start bit and samples each bit
//- receiver ignores a second stop bit
//- first stop bit moves frame into receive buffer
//- short characters read back with zero upper bits
//- frame is start low, data lsb first, parity, high stops
//- parity is xor of data bits, inverted for odd
//- async divider is 16, or 8 with double speed
//- polarity zero changes data on rising, samples on falling edge
`ifndef UTRD_REGS_VH
`define UTRD_REGS_VH

`define UTRD_WORD_W      9
`define UTRD_FIFO_DEPTH  8
`define UTRD_FIFO_AW     3
`define UTRD_OS_LAST_N   4'hF
`define UTRD_OS_LAST_D   4'h7
`define UTRD_OS_MID_N    4'h7
`define UTRD_OS_MID_D    4'h3
`define UTRD_CS_NINE     3'h7
`define UTRD_LINE_IDLE   1'b1
`define UTRD_LINE_START  1'b0
`define UTRD_TXE_RST     1'b1
`define UTRD_SYNC_RST    1'b1

`endif

// ### src/utrd_core.v
`timescale 1ns/100ps
`default_nettype none
`include "utrd_regs.vh"

module utrd_core (
	input  wire        mclk,
	input  wire        arst_n,
	input  wire        clk_en,
	input  wire        cpu_wr_data,
	input  wire [7:0]  cpu_wdata,
	input  wire        cpu_rd_data,
	output wire [7:0]  rx_data,
	output wire        rx_ninth_bit,
	output wire        rx_ready_flag,
	input  wire        tx_enable,
	input  wire        rx_enable,
	input  wire        sync_mode,
	input  wire        sync_master,
	input  wire        sync_clock_polarity,
	input  wire        double_speed_bit,
	input  wire [11:0] rate_divisor,
	input  wire [2:0]  char_size_field,
	input  wire        parity_enable_bit,
	input  wire        parity_odd,
	input  wire        stop_bits_select,
	input  wire        tx_ninth_bit,
	input  wire        tx_empty_irq_enable,
	input  wire        tx_done_irq_enable,
	input  wire        global_irq_enable,
	input  wire        tx_done_irq_ack,
	input  wire        tx_done_clear,
	output wire        tx_buffer_empty_flag,
	output wire        tx_done_flag,
	output wire        irq_tx_empty,
	output wire        irq_tx_done,
	output wire        txd_out,
	output wire        txd_oe,
	input  wire        rxd_in,
	input  wire        sync_clock_pin_in,
	output wire        sync_clock_pin_out,
	output wire        sync_clock_pin_oe
);

	// ************************************************
	// functions and states
	// ************************************************
	localparam T_IDLE  = 3'h0;
	localparam T_START = 3'h1;
	localparam T_DATA  = 3'h2;
	localparam T_PAR   = 3'h3;
	localparam T_STOP  = 3'h4;
	localparam T_END   = 3'h5;

	localparam R_IDLE  = 3'h0;
	localparam R_START = 3'h1;
	localparam R_DATA  = 3'h2;
	localparam R_PAR   = 3'h3;
	localparam R_STOP  = 3'h4;
	localparam R_HOLD  = 3'h5;

	// data bits per character; one decoder for both directions
	function [3:0] nbits;
		input [2:0] cs;
		begin
			case (cs)
				3'h0: nbits = 4'h5;
				3'h1: nbits = 4'h6;
				3'h2: nbits = 4'h7;
				3'h3: nbits = 4'h8;
				`UTRD_CS_NINE: nbits = 4'h9;
				default: nbits = 4'h8;
			endcase
		end
	endfunction

	function [8:0] mask9;
		input [8:0] v;
		input [3:0] n;
		begin
			mask9 = v & (9'h1FF >> (4'h9 - n));
		end
	endfunction

	wire [3:0] nb = nbits(char_size_field);

	// ************************************************
	// pin synchronisers
	// ************************************************
	wire [1:0] pins_s;
	wire       rxd_s  = pins_s[0];
	wire       xck_s  = pins_s[1];

	utrd_sync #(
		.WIDTH (2)
	) u_sync (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.async_in ({sync_clock_pin_in, rxd_in}),
		.sync_out (pins_s)
	);

	// ************************************************
	// rate divider and sync clock
	// ************************************************
	reg [11:0] presc_reg;
	reg        ptick_reg;
	reg        xck_reg;
	reg        xck_oe_reg;
	reg        xprev_reg;
	reg        tx_active_reg;

	wire run     = tx_active_reg || rx_enable;
	wire is_mstr = sync_mode && sync_master;
	wire xlev    = is_mstr ? xck_reg : xck_s;
	wire x_rise  = xlev && !xprev_reg;
	wire x_fall  = !xlev && xprev_reg;
	wire chg_edg = sync_clock_polarity ? x_fall : x_rise;
	wire smp_edg = sync_clock_polarity ? x_rise : x_fall;

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			presc_reg  <= 12'h000;
			ptick_reg  <= 1'b0;
			xck_reg    <= 1'b0;
			xck_oe_reg <= 1'b0;
			xprev_reg  <= 1'b0;
		end else if (clk_en) begin
			xprev_reg <= xlev;
			if (!run) begin
				presc_reg <= rate_divisor;
				ptick_reg <= 1'b0;
			end else if (presc_reg == 12'h000) begin
				presc_reg <= rate_divisor;
				ptick_reg <= 1'b1;
			end else begin
				presc_reg <= presc_reg - 12'h001;
				ptick_reg <= 1'b0;
			end
			// master clock toggles each tick: half period is divisor+1
			if (is_mstr && run) begin
				if (ptick_reg)
					xck_reg <= !xck_reg;
			end else begin
				xck_reg <= sync_clock_polarity;
			end
			xck_oe_reg <= is_mstr && run;
		end
	end

	wire [3:0] os_last = double_speed_bit ? `UTRD_OS_LAST_D : `UTRD_OS_LAST_N;
	wire [3:0] os_mid  = double_speed_bit ? `UTRD_OS_MID_D : `UTRD_OS_MID_N;

	// ************************************************
	// transmitter
	// ************************************************
	reg [2:0] tx_st_reg;
	reg [3:0] tx_os_reg;
	reg [8:0] txbuf_reg;
	reg       tx_empty_reg;
	reg [8:0] tx_sh_reg;
	reg       tx_par_reg;
	reg [3:0] tx_bc_reg;
	reg       tx_stc_reg;
	reg       txd_reg;
	reg       tx_done_reg;
	reg       irq_te_reg;
	reg       irq_td_reg;

	wire tx_strobe = sync_mode ? chg_edg : (ptick_reg && tx_os_reg == os_last);
	wire [8:0] tx_word = mask9({tx_ninth_bit, cpu_wdata}, nb);
	wire tx_load  = !tx_empty_reg && tx_active_reg;
	wire tx_fin   = tx_strobe && tx_st_reg == T_END && !tx_load;
	wire tx_take  = tx_load && (tx_st_reg == T_IDLE
			|| (tx_st_reg == T_END && tx_strobe));

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_os_reg <= 4'h0;
		end else if (clk_en) begin
			// wrap only on a tick, or a slow divisor would never reach the strobe
			if (sync_mode)
				tx_os_reg <= 4'h0;
			else if (ptick_reg)
				tx_os_reg <= (tx_os_reg == os_last) ? 4'h0 : tx_os_reg + 4'h1;
		end
	end

	// buffer and its empty flag
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txbuf_reg    <= 9'h000;
			tx_empty_reg <= `UTRD_TXE_RST;
		end else if (clk_en) begin
			if (cpu_wr_data) begin
				txbuf_reg    <= tx_word;
				tx_empty_reg <= 1'b0;
			end else if (tx_take) begin
				tx_empty_reg <= 1'b1;
			end
		end
	end

	// deferred disable: pin is held until nothing is left to send
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_active_reg <= 1'b0;
		end else if (clk_en) begin
			if (tx_enable)
				tx_active_reg <= 1'b1;
			else if (tx_st_reg == T_IDLE && tx_empty_reg && !cpu_wr_data)
				tx_active_reg <= 1'b0;
		end
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_reg  <= T_IDLE;
			tx_sh_reg  <= 9'h000;
			tx_par_reg <= 1'b0;
			tx_bc_reg  <= 4'h0;
			tx_stc_reg <= 1'b0;
			txd_reg    <= `UTRD_LINE_IDLE;
		end else if (clk_en) begin
			if (tx_take) begin
				tx_sh_reg  <= txbuf_reg;
				tx_par_reg <= (^txbuf_reg) ^ parity_odd;
			end
			case (tx_st_reg)
				T_IDLE: begin
					txd_reg <= `UTRD_LINE_IDLE;
					if (tx_take)
						tx_st_reg <= T_START;
				end
				T_START: begin
					if (tx_strobe) begin
						txd_reg   <= `UTRD_LINE_START;
						tx_bc_reg <= 4'h0;
						tx_st_reg <= T_DATA;
					end
				end
				T_DATA: begin
					if (tx_strobe) begin
						txd_reg   <= tx_sh_reg[0];
						tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
						tx_bc_reg <= tx_bc_reg + 4'h1;
						if (tx_bc_reg == nb - 4'h1)
							tx_st_reg <= parity_enable_bit ? T_PAR : T_STOP;
					end
				end
				T_PAR: begin
					if (tx_strobe) begin
						txd_reg   <= tx_par_reg;
						tx_st_reg <= T_STOP;
					end
				end
				T_STOP: begin
					if (tx_strobe) begin
						txd_reg    <= `UTRD_LINE_IDLE;
						tx_stc_reg <= 1'b0;
						if (tx_stc_reg || !stop_bits_select)
							tx_st_reg <= T_END;
						else
							tx_stc_reg <= 1'b1;
					end
				end
				T_END: begin
					// this strobe ends the last stop bit; a waiting word
					// starts its start bit on the same strobe
					if (tx_strobe) begin
						if (tx_load) begin
							txd_reg   <= `UTRD_LINE_START;
							tx_bc_reg <= 4'h0;
							tx_st_reg <= T_DATA;
						end else begin
							tx_st_reg <= T_IDLE;
						end
					end
				end
				default: tx_st_reg <= T_IDLE;
			endcase
		end
	end

	// done flag: setting beats a clear in the same cycle
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_done_reg <= 1'b0;
			irq_te_reg  <= 1'b0;
			irq_td_reg  <= 1'b0;
		end else if (clk_en) begin
			if (tx_fin)
				tx_done_reg <= 1'b1;
			else if (tx_done_irq_ack || tx_done_clear)
				tx_done_reg <= 1'b0;
			irq_te_reg <= tx_empty_irq_enable && global_irq_enable
				&& tx_empty_reg && !cpu_wr_data;
			irq_td_reg <= tx_done_irq_enable && global_irq_enable
				&& (tx_fin || (tx_done_reg
				&& !tx_done_irq_ack && !tx_done_clear));
		end
	end

	// ************************************************
	// receiver
	// ************************************************
	reg [2:0] rx_st_reg;
	reg [3:0] rx_os_reg;
	reg [8:0] rx_sh_reg;
	reg [3:0] rx_bc_reg;
	reg [7:0] rx_data_reg;
	reg       rx_ninth_reg;
	reg       rx_rdy_reg;

	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [8:0] fifo_out_data;

	wire rx_samp = sync_mode ? smp_edg
			: (ptick_reg && rx_os_reg == os_mid);
	wire [8:0] rx_word = mask9(rx_sh_reg >> (4'h9 - nb), nb);
	wire rx_push = rx_st_reg == R_HOLD;
	wire rx_pop  = cpu_rd_data && rx_rdy_reg;

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st_reg <= R_IDLE;
			rx_os_reg <= 4'h0;
			rx_sh_reg <= 9'h000;
			rx_bc_reg <= 4'h0;
		end else if (clk_en) begin
			if (rx_st_reg == R_IDLE)
				rx_os_reg <= 4'h0;
			else if (ptick_reg)
				rx_os_reg <= (rx_os_reg == os_last) ? 4'h0 : rx_os_reg + 4'h1;
			if (!rx_enable) begin
				rx_st_reg <= R_IDLE;
			end else begin
				case (rx_st_reg)
					R_IDLE: begin
						rx_bc_reg <= 4'h0;
						if (sync_mode) begin
							if (smp_edg && rxd_s == `UTRD_LINE_START)
								rx_st_reg <= R_DATA;
						end else if (ptick_reg && rxd_s == `UTRD_LINE_START) begin
							rx_st_reg <= R_START;
						end
					end
					R_START: begin
						// a glitch shorter than half a bit is not a start
						if (rx_samp)
							rx_st_reg <= rxd_s ? R_IDLE : R_DATA;
					end
					R_DATA: begin
						if (rx_samp) begin
							rx_sh_reg <= {rxd_s, rx_sh_reg[8:1]};
							rx_bc_reg <= rx_bc_reg + 4'h1;
							if (rx_bc_reg == nb - 4'h1)
								rx_st_reg <= parity_enable_bit ? R_PAR : R_STOP;
						end
					end
					R_PAR: begin
						if (rx_samp)
							rx_st_reg <= R_STOP;
					end
					R_STOP: begin
						// only the first stop bit is looked at
						if (rx_samp)
							rx_st_reg <= R_HOLD;
					end
					R_HOLD: begin
						// held while the buffer is full: no new start taken
						if (fifo_in_ready)
							rx_st_reg <= R_IDLE;
					end
					default: rx_st_reg <= R_IDLE;
				endcase
			end
		end
	end

	utrd_fifo #(
		.WIDTH (`UTRD_WORD_W),
		.DEPTH (`UTRD_FIFO_DEPTH),
		.AW    (`UTRD_FIFO_AW)
	) u_rxbuf (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.flush     (!rx_enable),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_word),
		.out_valid (fifo_out_valid),
		.out_ready (rx_pop),
		.out_data  (fifo_out_data)
	);

	// registered view of the buffer head; it trails a read by one cycle
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_data_reg  <= 8'h00;
			rx_ninth_reg <= 1'b0;
			rx_rdy_reg   <= 1'b0;
		end else if (clk_en) begin
			rx_rdy_reg   <= fifo_out_valid && !rx_pop && rx_enable;
			rx_data_reg  <= fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
			rx_ninth_reg <= fifo_out_valid && fifo_out_data[8];
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign rx_data              = rx_data_reg;
	assign rx_ninth_bit         = rx_ninth_reg;
	assign rx_ready_flag        = rx_rdy_reg;
	assign tx_buffer_empty_flag = tx_empty_reg;
	assign tx_done_flag         = tx_done_reg;
	assign irq_tx_empty         = irq_te_reg;
	assign irq_tx_done          = irq_td_reg;
	assign txd_out              = txd_reg;
	assign txd_oe               = tx_active_reg;
	assign sync_clock_pin_out   = xck_reg;
	assign sync_clock_pin_oe    = xck_oe_reg;

endmodule // utrd_core
`default_nettype wire

// ### src/utrd_fifo.v
`timescale 1ns/100ps
`default_nettype none
`include "utrd_regs.vh"

module utrd_fifo #(
	parameter WIDTH = `UTRD_WORD_W,
	parameter DEPTH = `UTRD_FIFO_DEPTH,
	parameter AW    = `UTRD_FIFO_AW
) (
	input  wire             mclk,
	input  wire             arst_n,
	input  wire             clk_en,
	input  wire             flush,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;

	localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
	localparam [AW:0]   CNT_ONE = {{AW{1'b0}}, 1'b1};

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = mem_reg[rd_ptr_reg];

	always @(posedge mclk) begin
		if (clk_en && push && !flush) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else if (clk_en) begin
			if (flush) begin
				wr_ptr_reg <= {AW{1'b0}};
				rd_ptr_reg <= {AW{1'b0}};
				count_reg  <= {(AW+1){1'b0}};
			end else begin
				if (push)
					wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
				if (pop)
					rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
				if (push && !pop)
					count_reg <= count_reg + CNT_ONE;
				else if (pop && !push)
					count_reg <= count_reg - CNT_ONE;
			end
		end
	end

endmodule // utrd_fifo
`default_nettype wire

// ### src/utrd_sync.v
`timescale 1ns/100ps
`default_nettype none
`include "utrd_regs.vh"

module utrd_sync #(
	parameter WIDTH = 2
) (
	input  wire             mclk,
	input  wire             arst_n,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// first stage feeds only the second
			always @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					stage1_reg[i] <= `UTRD_SYNC_RST;
					stage2_reg[i] <= `UTRD_SYNC_RST;
				end else if (clk_en) begin
					stage1_reg[i] <= async_in[i];
					stage2_reg[i] <= stage1_reg[i];
				end
			end
		end
	endgenerate

	assign sync_out = stage2_reg;

endmodule // utrd_sync
`default_nettype wire
